// ### design/fsr_pkg.sv
/*
 * Package for the fault status and trim register bank: offsets, field
 * positions, reset values and the packed carriers used by the bank.
 * Assumes an 8-bit register port driven by a serial-bus slave elsewhere.
 */
package fsr_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	localparam logic [7:0] OFF_STATUS         = 8'h02;
	localparam logic [7:0] OFF_CURRENT_LIMIT  = 8'h04;
	localparam logic [7:0] OFF_SHARE_OFFSET   = 8'h05;
	localparam logic [7:0] OFF_SHARE_SLOPE    = 8'h06;
	localparam logic [7:0] OFF_LOAD_OVERVOLTAGE_TRIM        = 8'h08;
	localparam logic [7:0] OFF_LOCAL_UV       = 8'h09;
	localparam logic [7:0] OFF_LOCAL_OV       = 8'h0a;
	localparam logic [7:0] OFF_OVERTEMP       = 8'h0b;
	localparam logic [7:0] OFF_AC_SENSE       = 8'h0c;
	localparam logic [7:0] OFF_DIVIDER_OFFSET = 8'h14;
	localparam logic [7:0] OFF_AMP_OFFSET     = 8'h15;
	localparam logic [7:0] OFF_SENSE_RANGE    = 8'h16;
	localparam logic [7:0] OFF_OFFSET_CT      = 8'h17;
	localparam logic [7:0] OFF_FALSE_CLAMP    = 8'h18;
	localparam logic [7:0] OFF_LOAD_SETPOINT  = 8'h19;
	localparam logic [7:0] OFF_STICKY_MON     = 8'h2a;
	localparam logic [7:0] OFF_STICKY_SUPPLY  = 8'h2b;
	localparam logic [7:0] OFF_STICKY_PIN     = 8'h2c;

	// status register bit positions
	localparam int unsigned ST_FAULT    = 0;
	localparam int unsigned ST_PULSE    = 1;
	localparam int unsigned ST_OCP_RUN  = 2;
	localparam int unsigned ST_DC_GOOD  = 3;
	localparam int unsigned ST_LINK     = 4;
	localparam int unsigned ST_ENABLE   = 5;
	localparam int unsigned ST_POWER_RQ = 6;
	localparam int unsigned ST_AC_SENSE = 7;

	// trim field positions
	localparam int unsigned LIMIT_LSB      = 3;
	localparam int unsigned SLOPE_LSB      = 1;
	localparam int unsigned OTEMP_LSB      = 4;
	localparam int unsigned AC_THR_LSB     = 3;
	localparam int unsigned AC_HYST_MSB    = 2;
	localparam int unsigned DIV_RANGE_MSB  = 5;
	localparam int unsigned DIV_RANGE_LSB  = 3;
	localparam int unsigned SENSE_RNG_MSB  = 2;
	localparam int unsigned AMP_RANGE_MSB  = 3;
	localparam int unsigned CT_GAIN_BIT    = 5;

	// writable bits of each trim register; others read as zero
	localparam logic [7:0] MASK_FULL         = 8'hff;
	localparam logic [7:0] MASK_LIMIT        = 8'hf8;
	localparam logic [7:0] MASK_SLOPE        = 8'hfe;
	localparam logic [7:0] MASK_OTEMP        = 8'hf0;
	localparam logic [7:0] MASK_SENSE_RANGE  = 8'h3f;
	localparam logic [7:0] MASK_OFFSET_CT    = 8'h2f;

	localparam logic [7:0] TRIM_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO  = 8'h00;

	// register port request
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} fsr_req_t;

	// live fault conditions, active high, in sticky register bit order
	typedef struct packed {
		logic ovfault;
		logic uvfault;
		logic ocp_timeout;
		logic monitor_input_one;
		logic mon2;
		logic mon3;
		logic mon4;
		logic mon5;
	} fsr_mon_faults_t;

	typedef struct packed {
		logic share;
		logic output_switch;
		logic reverse;
		logic supply;
		logic ground;
		logic int_ref;
		logic ext_ref;
		logic supply_ov;
	} fsr_supply_faults_t;

	// decoded trim fields for the analogue circuits
	typedef struct packed {
		logic [7:0] load_setpoint;
		logic [7:0] remote_overvoltage_level;
		logic [7:0] false_low_clamp_level;
		logic [7:0] local_uv_level;
		logic [7:0] local_ov_level;
		logic [7:0] divider_offset_code;
		logic [2:0] divider_range;
		logic [7:0] amplifier_offset_code;
		logic [3:0] amplifier_range;
		logic [2:0] sense_range;
		logic       transformer_gain_select;
		logic [7:0] share_offset;
		logic [6:0] share_slope;
		logic [4:0] current_limit;
		logic [3:0] overtemp_level;
		logic [4:0] ac_threshold;
		logic [2:0] ac_hysteresis;
	} fsr_trims_t;

endpackage : fsr_pkg

// ### design/fsr_regs.sv
/*
 * Fault status and trim register bank: live status, three read-to-clear
 * sticky fault registers and the trim registers of the analogue circuits.
 * Assumes a serial-bus slave on the same clock issues one-cycle rd/wr
 * strobes; read data is registered and valid the cycle after rd.
 */
// Functional notes
// - status bit 2 shows overcurrent timer running
// - status bit 3 mirrors dc-good pin
// - status bit 4 mirrors power link pin
// - status bit 5 mirrors power enable input
// - status bit 6 mirrors power-on request pin
// - status bit 7 mirrors ac-sense pin
// - register 2Ah latches monitor and voltage faults
// - register 2Bh latches supply and switch faults
// - read clears latch unless fault still active
// - 19h holds 8-bit load setpoint code
// - 08h holds 8-bit load overvoltage code
// - 18h holds 8-bit false clamp code
// - 09h holds 8-bit local undervoltage code
// - 0Ah holds 8-bit local overvoltage code
// - divider offset 14h, range 16h bits 5:3
// - amplifier offset 15h, range 17h bits 3:0
// - sense range in 16h bits 2:0
// - transformer gain select is 17h bit 5
// - share offset 05h, slope 06h bits 7:1
// - current limit in 04h bits 7:3
// - ac threshold 0Ch 7:3, hysteresis 2:0
`timescale 1ns/1ps

module fsr_regs
	import fsr_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire fsr_req_t            req,
	output logic [DATA_W-1:0]        rdata,
	output logic                     rvalid,
	input  wire logic                dc_good_pin,
	input  wire logic                power_link_pin,
	input  wire logic                power_enable_input,
	input  wire logic                power_request_pin,
	input  wire logic                ac_sense_pin,
	input  wire logic                fault_latched,
	input  wire logic                pulses_present,
	input  wire logic                ocp_timer_running,
	input  wire fsr_mon_faults_t     mon_faults,
	input  wire fsr_supply_faults_t  supply_faults,
	output fsr_trims_t               trims
);

	// pins arrive asynchronously; two flops before anything reads them
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_meta <= 5'h00;
			pin_sync <= 5'h00;
		end else begin
			pin_meta <= {ac_sense_pin, power_request_pin, power_enable_input,
				power_link_pin, dc_good_pin};
			pin_sync <= pin_meta;
		end
	end

	logic       dc_good_pin_state;
	logic       link_state;
	logic       enable_state;
	logic       request_state;
	logic       ac_state;
	logic [7:0] status;

	assign dc_good_pin_state = pin_sync[0];
	assign link_state        = pin_sync[1];
	assign enable_state      = pin_sync[2];
	assign request_state     = pin_sync[3];
	assign ac_state          = pin_sync[4];

	always_comb begin
		status              = READ_ZERO;
		status[ST_FAULT]    = fault_latched;
		status[ST_PULSE]    = pulses_present;
		status[ST_OCP_RUN]  = ocp_timer_running;
		status[ST_DC_GOOD]  = dc_good_pin_state;
		status[ST_LINK]     = link_state;
		status[ST_ENABLE]   = enable_state;
		status[ST_POWER_RQ] = request_state;
		status[ST_AC_SENSE] = ac_state;
	end

	// the third sticky register flags pin and status bits that are bad;
	// for the good-high bits a low level counts as the fault
	logic [7:0] pin_faults;

	always_comb begin
		pin_faults              = READ_ZERO;
		pin_faults[ST_FAULT]    = fault_latched;
		pin_faults[ST_PULSE]    = ~pulses_present;
		pin_faults[ST_OCP_RUN]  = ocp_timer_running;
		pin_faults[ST_DC_GOOD]  = ~dc_good_pin_state;
		pin_faults[ST_LINK]     = ~link_state;
		pin_faults[ST_ENABLE]   = ~enable_state;
		pin_faults[ST_POWER_RQ] = ~request_state;
		pin_faults[ST_AC_SENSE] = ~ac_state;
	end

	function automatic logic is_read(input fsr_req_t r, input logic [7:0] off);
		return r.rd && (r.addr == off);
	endfunction : is_read

	function automatic logic is_write(input fsr_req_t r, input logic [7:0] off);
		return r.wr && (r.addr == off);
	endfunction : is_write

	// set wins over clear, and a read only clears bits whose fault has gone
	function automatic logic [7:0] sticky_next(input logic [7:0] cur,
		input logic [7:0] live, input logic rd_now);
		logic [7:0] kept;
		kept = rd_now ? READ_ZERO : cur;
		return kept | live;
	endfunction : sticky_next

	logic [7:0] sticky_monitor_faults;
	logic [7:0] sticky_supply_faults;
	logic [7:0] sticky_pin_faults;

	// sticky registers have no write path at all
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sticky_monitor_faults <= READ_ZERO;
			sticky_supply_faults  <= READ_ZERO;
			sticky_pin_faults     <= READ_ZERO;
		end else begin
			sticky_monitor_faults <= sticky_next(sticky_monitor_faults, mon_faults,
				is_read(req, OFF_STICKY_MON));
			sticky_supply_faults  <= sticky_next(sticky_supply_faults, supply_faults,
				is_read(req, OFF_STICKY_SUPPLY));
			sticky_pin_faults     <= sticky_next(sticky_pin_faults, pin_faults,
				is_read(req, OFF_STICKY_PIN));
		end
	end

	logic [7:0] current_limit_trim;
	logic [7:0] share_offset_trim;
	logic [7:0] share_slope_trim;
	logic [7:0] load_overvoltage_trim;
	logic [7:0] local_undervoltage_trim;
	logic [7:0] local_overvoltage_trim;
	logic [7:0] overtemp_threshold_trim;
	logic [7:0] ac_sense_threshold_trim;
	logic [7:0] divider_offset_trim;
	logic [7:0] amplifier_offset_trim;
	logic [7:0] sense_range_select;
	logic [7:0] offset_and_transformer_range;
	logic [7:0] false_clamp_trim;
	logic [7:0] load_setpoint_trim;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			current_limit_trim           <= TRIM_RESET;
			share_offset_trim            <= TRIM_RESET;
			share_slope_trim             <= TRIM_RESET;
			load_overvoltage_trim        <= TRIM_RESET;
			local_undervoltage_trim      <= TRIM_RESET;
			local_overvoltage_trim       <= TRIM_RESET;
			overtemp_threshold_trim      <= TRIM_RESET;
			ac_sense_threshold_trim      <= TRIM_RESET;
			divider_offset_trim          <= TRIM_RESET;
			amplifier_offset_trim        <= TRIM_RESET;
			sense_range_select           <= TRIM_RESET;
			offset_and_transformer_range <= TRIM_RESET;
			false_clamp_trim             <= TRIM_RESET;
			load_setpoint_trim           <= TRIM_RESET;
		end else begin
			if (is_write(req, OFF_CURRENT_LIMIT))
				current_limit_trim <= req.wdata & MASK_LIMIT;
			if (is_write(req, OFF_SHARE_OFFSET))
				share_offset_trim <= req.wdata & MASK_FULL;
			if (is_write(req, OFF_SHARE_SLOPE))
				share_slope_trim <= req.wdata & MASK_SLOPE;
			if (is_write(req, OFF_LOAD_OVERVOLTAGE_TRIM))
				load_overvoltage_trim <= req.wdata & MASK_FULL;
			if (is_write(req, OFF_LOCAL_UV))
				local_undervoltage_trim <= req.wdata & MASK_FULL;
			if (is_write(req, OFF_LOCAL_OV))
				local_overvoltage_trim <= req.wdata & MASK_FULL;
			if (is_write(req, OFF_OVERTEMP))
				overtemp_threshold_trim <= req.wdata & MASK_OTEMP;
			if (is_write(req, OFF_AC_SENSE))
				ac_sense_threshold_trim <= req.wdata & MASK_FULL;
			if (is_write(req, OFF_DIVIDER_OFFSET))
				divider_offset_trim <= req.wdata & MASK_FULL;
			if (is_write(req, OFF_AMP_OFFSET))
				amplifier_offset_trim <= req.wdata & MASK_FULL;
			if (is_write(req, OFF_SENSE_RANGE))
				sense_range_select <= req.wdata & MASK_SENSE_RANGE;
			if (is_write(req, OFF_OFFSET_CT))
				offset_and_transformer_range <= req.wdata & MASK_OFFSET_CT;
			if (is_write(req, OFF_FALSE_CLAMP))
				false_clamp_trim <= req.wdata & MASK_FULL;
			if (is_write(req, OFF_LOAD_SETPOINT))
				load_setpoint_trim <= req.wdata & MASK_FULL;
		end
	end

	// field extraction for the analogue side; limited by the field widths
	always_comb begin
		trims.load_setpoint            = load_setpoint_trim;
		trims.remote_overvoltage_level = load_overvoltage_trim;
		trims.false_low_clamp_level    = false_clamp_trim;
		trims.local_uv_level           = local_undervoltage_trim;
		trims.local_ov_level           = local_overvoltage_trim;
		trims.divider_offset_code      = divider_offset_trim;
		trims.divider_range            = sense_range_select[DIV_RANGE_MSB:DIV_RANGE_LSB];
		trims.amplifier_offset_code    = amplifier_offset_trim;
		trims.amplifier_range          = offset_and_transformer_range[AMP_RANGE_MSB:0];
		trims.sense_range              = sense_range_select[SENSE_RNG_MSB:0];
		trims.transformer_gain_select  = offset_and_transformer_range[CT_GAIN_BIT];
		trims.share_offset             = share_offset_trim;
		trims.share_slope              = share_slope_trim[7:SLOPE_LSB];
		trims.current_limit            = current_limit_trim[7:LIMIT_LSB];
		trims.overtemp_level           = overtemp_threshold_trim[7:OTEMP_LSB];
		trims.ac_threshold             = ac_sense_threshold_trim[7:AC_THR_LSB];
		trims.ac_hysteresis            = ac_sense_threshold_trim[AC_HYST_MSB:0];
	end

	logic [7:0] next_rdata;

	always_comb begin
		unique case (req.addr)
			OFF_STATUS:         next_rdata = status;
			OFF_CURRENT_LIMIT:  next_rdata = current_limit_trim;
			OFF_SHARE_OFFSET:   next_rdata = share_offset_trim;
			OFF_SHARE_SLOPE:    next_rdata = share_slope_trim;
			OFF_LOAD_OVERVOLTAGE_TRIM:        next_rdata = load_overvoltage_trim;
			OFF_LOCAL_UV:       next_rdata = local_undervoltage_trim;
			OFF_LOCAL_OV:       next_rdata = local_overvoltage_trim;
			OFF_OVERTEMP:       next_rdata = overtemp_threshold_trim;
			OFF_AC_SENSE:       next_rdata = ac_sense_threshold_trim;
			OFF_DIVIDER_OFFSET: next_rdata = divider_offset_trim;
			OFF_AMP_OFFSET:     next_rdata = amplifier_offset_trim;
			OFF_SENSE_RANGE:    next_rdata = sense_range_select;
			OFF_OFFSET_CT:      next_rdata = offset_and_transformer_range;
			OFF_FALSE_CLAMP:    next_rdata = false_clamp_trim;
			OFF_LOAD_SETPOINT:  next_rdata = load_setpoint_trim;
			// the value returned is the latch before this read's clear, ORed with the live faults
			OFF_STICKY_MON:     next_rdata = sticky_monitor_faults | mon_faults;
			OFF_STICKY_SUPPLY:  next_rdata = sticky_supply_faults | supply_faults;
			OFF_STICKY_PIN:     next_rdata = sticky_pin_faults | pin_faults;
			default:            next_rdata = READ_ZERO;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata  <= READ_ZERO;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			if (req.rd)
				rdata <= next_rdata;
		end
	end

endmodule : fsr_regs

// ### tb/fsr_regs_props.sv
/*
 * Checker for the fault status and trim register bank, bound to its ports.
 * Assumes one clock domain and an asynchronous active-high reset.
 */
`timescale 1ns/1ps

module fsr_regs_props
	import fsr_pkg::*;
(
	input wire logic               clk,
	input wire logic               rst,
	input wire fsr_req_t           req,
	input wire logic [DATA_W-1:0]  rdata,
	input wire logic               dc_good_pin,
	input wire logic               power_link_pin,
	input wire logic               power_enable_input,
	input wire logic               power_request_pin,
	input wire logic               ac_sense_pin,
	input wire logic               ocp_timer_running,
	input wire fsr_mon_faults_t    mon_faults,
	input wire fsr_supply_faults_t supply_faults,
	input wire fsr_trims_t         trims
);
	logic [1:0] up;
	wire logic [4:0] pins = {ac_sense_pin, power_request_pin, power_enable_input, power_link_pin, dc_good_pin};
	wire logic rd_mon = req.rd && req.addr == 8'h2a;

	// pin bits mean nothing until both sync stages have refilled after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			up <= 2'd0;
		else if (up != 2'd3)
			up <= up + 2'd1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_ocp_status: assert property (req.rd && req.addr == 8'h02 |=> rdata[2] == $past(ocp_timer_running))
		else $error("overcurrent timer bit wrong");
	a_pin_status: assert property ($stable(pins)[*3] ##0 (up == 2'd3 && req.rd && req.addr == 8'h02)
		|=> rdata[7:3] == $past(pins)) else $error("pin level bits wrong");
	a_mon_sticky: assert property (rd_mon |=> (rdata & $past(mon_faults)) == $past(mon_faults))
		else $error("live monitor fault missing from read");
	a_supply_sticky: assert property (req.rd && req.addr == 8'h2b
		|=> (rdata & $past(supply_faults)) == $past(supply_faults)) else $error("live supply fault missing");
	a_sticky_clear: assert property ((rd_mon && mon_faults == 8'h00) ##1 (rd_mon && mon_faults == 8'h00)
		|=> rdata == 8'h00) else $error("sticky latch not cleared by read");
	a_setpoint_trim: assert property (req.wr && req.addr == 8'h19 |=> trims.load_setpoint == $past(req.wdata))
		else $error("load setpoint not written");
	a_limit_trim: assert property (req.wr && req.addr == 8'h04 |=> trims.current_limit == $past(req.wdata[7:3]))
		else $error("current limit field wrong");
	a_slope_trim: assert property (req.wr && req.addr == 8'h06 |=> trims.share_slope == $past(req.wdata[7:1]))
		else $error("share slope field wrong");
	a_range_trim: assert property (req.wr && req.addr == 8'h16 |=>
		{trims.divider_range, trims.sense_range} == $past(req.wdata[5:0])) else $error("range fields wrong");
endmodule : fsr_regs_props

bind fsr_regs fsr_regs_props u_props (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
	.dc_good_pin(dc_good_pin), .power_link_pin(power_link_pin), .power_enable_input(power_enable_input),
	.power_request_pin(power_request_pin), .ac_sense_pin(ac_sense_pin), .ocp_timer_running(ocp_timer_running),
	.mon_faults(mon_faults), .supply_faults(supply_faults), .trims(trims));

// ### tb/fsr_host.sv
/*
 * Host model: issues one-cycle register reads and writes from the bus side.
 * Assumes the bank takes a request at the rising edge it is seen on.
 */
`timescale 1ns/1ps

module fsr_host
	import fsr_pkg::*;
(
	input wire logic clk,
	output fsr_req_t req
);
	initial req = '0;

	// held from a falling edge through the rising edge that takes it
	task automatic op(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{rd, wr, a, d};
		@(posedge clk);
	endtask : op

	task automatic idle();
		@(negedge clk);
		req = '0;
	endtask : idle

	// keep polling a sticky register; caller knows when it should read clear
	task automatic reread(input logic [7:0] a, input int n);
		repeat (n) op(1'b1, 1'b0, a, 8'h00);
	endtask : reread
endmodule : fsr_host

// ### tb/tb.sv
/*
 * Self-checking bench for the register bank: reads are queued with their
 * expected value and checked when rvalid appears. Assumes nothing outside.
 */
`timescale 1ns/1ps

module tb;
	import fsr_pkg::*;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               dc = 1'b0, lnk = 1'b0, en = 1'b0, prq = 1'b0, ac = 1'b0;
	logic               flt = 1'b0, pul = 1'b0, ocp = 1'b0;
	fsr_mon_faults_t    mf = '0;
	fsr_supply_faults_t sf = '0;
	fsr_req_t           req;
	logic [7:0]         rdata, r, a;
	logic               rvalid;
	fsr_trims_t         trims;
	logic [15:0]        q[$];
	logic [15:0]        e;
	int                 fail_count = 0;
	int                 n_tests = 0;
	logic [31:0]        seed = 32'h91bb23cf;
	// every bad-sense status state seen since reset; all pins start low
	logic [7:0]         pacc = 8'hfa;
	logic [7:0]         wv [14];
	logic [7:0]         offs [14] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c,
		8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19};
	logic [7:0]         masks [14] = '{8'hf8, 8'hff, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hf0, 8'hff,
		8'hff, 8'hff, 8'h3f, 8'h2f, 8'hff, 8'hff};

	always #2 clk = ~clk;

	fsr_host host (.clk(clk), .req(req));

	fsr_regs DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .dc_good_pin(dc),
		.power_link_pin(lnk), .power_enable_input(en), .power_request_pin(prq), .ac_sense_pin(ac),
		.fault_latched(flt), .pulses_present(pul), .ocp_timer_running(ocp), .mon_faults(mf),
		.supply_faults(sf), .trims(trims));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic check(input string nm, input logic [98:0] ex, input logic [98:0] got);
		n_tests++;
		if (got !== ex) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask : check

	task automatic rd(input logic [7:0] ad, input logic [7:0] ex);
		q.push_back({ad, ex});
		host.op(1'b1, 1'b0, ad, 8'h00);
	endtask : rd

	task automatic setf(input int k, input logic [7:0] v);
		if (k != 0)
			sf = fsr_supply_faults_t'(v);
		else
			mf = fsr_mon_faults_t'(v);
	endtask : setf

	task print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	always @(negedge clk) begin
		if (rvalid === 1'b1) begin
			if (q.size() == 0)
				check("unexpected rvalid", 99'd0, 99'd1);
			else begin
				e = q.pop_front();
				check($sformatf("register %h", e[15:8]), e[7:0], rdata);
			end
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		foreach (offs[i]) rd(offs[i], 8'h00);
		rd(8'h03, 8'h00);
		foreach (offs[i]) begin
			r = 8'(xs());
			wv[i] = r & masks[i];
			host.op(1'b0, 1'b1, offs[i], r);
			rd(offs[i], wv[i]);
		end
		host.idle();
		check("trims", {wv[13], wv[3], wv[12], wv[4], wv[5], wv[8], wv[10][5:3], wv[9], wv[11][3:0],
			wv[10][2:0], wv[11][5], wv[1], wv[2][7:1], wv[0][7:3], wv[6][7:4], wv[7]}, trims);
		repeat (4) begin
			r = 8'(xs());
			{ac, prq, en, lnk, dc, ocp, pul, flt} = r;
			// fault and ocp are bad when high, the other six when low
			pacc = pacc | (r ^ 8'hfa);
			repeat (3) @(negedge clk);
			rd(8'h02, r);
			host.op(1'b0, 1'b1, 8'h02, ~r);
			rd(8'h02, r);
			host.idle();
		end
		for (int k = 0; k < 2; k++) begin
			a = (k != 0) ? 8'h2b : 8'h2a;
			r = 8'(xs()) | 8'h01;
			setf(k, r);
			@(negedge clk);
			setf(k, 8'h00);
			host.op(1'b0, 1'b1, a, 8'hff);
			rd(a, r);
			rd(a, 8'h00);
			host.idle();
			setf(k, 8'h81);
			rd(a, 8'h81);
			host.idle();
			setf(k, 8'h00);
			q.push_back({a, 8'h81});
			q.push_back({a, 8'h00});
			q.push_back({a, 8'h00});
			host.reread(a, 3);
			host.idle();
		end
		// all good levels: the pin latch must give back its history once, then clear
		{ac, prq, en, lnk, dc, ocp, pul, flt} = 8'hfa;
		repeat (3) @(negedge clk);
		host.op(1'b0, 1'b1, 8'h2c, 8'h00);
		rd(8'h2c, pacc);
		rd(8'h2c, 8'h00);
		host.idle();
		host.op(1'b0, 1'b1, 8'h07, 8'hff);
		rd(8'h07, 8'h00);
		host.idle();
		repeat (4) @(negedge clk);
		check("pending reads", 99'd0, 99'(q.size()));
		print_verdict();
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		print_verdict();
	end
endmodule : tb
